//--- hdl/ocm_core.sv
// Output compare channel: mode decode, match events, pin drive
`timescale 1ns/1ps
`include "ocm_map.svh"

module ocm_core
    import ocm_pkg::*;
(
    // Clock, reset, enable
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Software settings
    input wire logic [`OCM_CTRL_W-1:0] compare_control_one,
    input ocm_cnt_t primary_compare_value,
    input ocm_cnt_t secondary_compare_value,
    // Timer
    input ocm_cnt_t compare_timer_count,
    input wire logic timer_period_tick,
    // Pin and status
    output logic compare_output_pin,
    output ocm_state_t compare_state
);

    // Mode field of control one
    logic [2:0] mode; // Requested mode
    logic [2:0] mode_q; // Mode seen last enabled cycle
    logic [2:0] next_mode_q; // Next held mode
    logic mode_chg; // Mode differs from held one
    logic pwm; // Either PWM mode

    // Compare values
    ocm_cmp_pair_t written; // Values as software holds them
    ocm_cmp_pair_t act; // Values in use
    logic load; // Reload the values in use

    // Match detection
    logic pri_eq; // Count equals primary
    logic sec_eq; // Count equals secondary
    logic zero_eq; // Count is zero
    logic pri_eq_q; // Last primary equality
    logic sec_eq_q; // Last secondary equality
    logic zero_eq_q; // Last zero equality
    logic next_pri_eq_q;
    logic next_sec_eq_q;
    logic next_zero_eq_q;
    logic pri_hit; // Primary match event
    logic sec_hit; // Secondary match event
    logic zero_hit; // Timer reached zero

    // Pin state
    logic next_pin; // Next pin level
    ocm_state_t next_state; // Next sequence state

    // Decode the mode field
    always_comb begin
        mode = compare_control_one[`OCM_MODE_MSB:`OCM_MODE_LSB]; // R1
        mode_chg = (mode != mode_q);
        pwm = (mode == `OCM_MODE_PWM_EDGE) || (mode == `OCM_MODE_PWM_CTR);
    end

    // Reload the values in use
    // Outside PWM they follow the written ones every enabled cycle; in PWM only
    // at the period tick, or at once when a PWM mode is entered.
    always_comb begin
        written.pri = primary_compare_value;
        written.sec = secondary_compare_value;
        load = !pwm || timer_period_tick || mode_chg; // R10 R11
    end

    // Holding register pair
    ocm_cmp_buffer i_ocm_cmp_buffer (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .load(load),
        .written(written),
        .active(act)
    );

    // Equality and event detection
    // A prescaled timer holds one count for many edges, so only the
    // first edge of an equality counts as a match.
    always_comb begin
        pri_eq = (compare_timer_count == act.pri);
        sec_eq = (compare_timer_count == act.sec);
        zero_eq = (compare_timer_count == `OCM_CNT_ZERO);
        pri_hit = clk_en && pri_eq && !pri_eq_q;
        sec_hit = clk_en && sec_eq && !sec_eq_q;
        zero_hit = clk_en && zero_eq && !zero_eq_q;
        next_pri_eq_q = clk_en ? pri_eq : pri_eq_q;
        next_sec_eq_q = clk_en ? sec_eq : sec_eq_q;
        next_zero_eq_q = clk_en ? zero_eq : zero_eq_q;
        next_mode_q = clk_en ? mode : mode_q;
    end

    // Event history and held mode
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pri_eq_q <= 1'h0;
            sec_eq_q <= 1'h0;
            zero_eq_q <= 1'h0;
            mode_q <= `OCM_MODE_RST;
        end else begin
            pri_eq_q <= next_pri_eq_q;
            sec_eq_q <= next_sec_eq_q;
            zero_eq_q <= next_zero_eq_q;
            mode_q <= next_mode_q;
        end
    end

    // Pin and sequence next values
    always_comb begin
        next_pin = compare_output_pin;
        next_state = compare_state;
        if (!clk_en) begin
            // Frozen
            next_pin = compare_output_pin;
        end else if (mode_chg) begin
            // New mode: set the starting level
            next_pin = (mode == `OCM_MODE_SS_LO); // R7 R8 R4 R5
            next_state = (mode == `OCM_MODE_OFF) ? ST_OFF : ST_WAIT_PRI;
        end else begin
            case (mode)
                `OCM_MODE_OFF: begin
                    // Disabled: pin parked low
                    next_pin = 1'h0; // R9
                    next_state = ST_OFF;
                end
                `OCM_MODE_SS_HI: begin
                    if (compare_state == ST_WAIT_PRI && pri_hit) begin
                        next_pin = 1'h1; // R8
                        next_state = ST_DONE;
                    end
                end
                `OCM_MODE_SS_LO: begin
                    if (compare_state == ST_WAIT_PRI && pri_hit) begin
                        next_pin = 1'h0; // R7
                        next_state = ST_DONE;
                    end
                end
                `OCM_MODE_TOGGLE: begin
                    if (pri_hit) begin
                        next_pin = !compare_output_pin; // R6
                    end
                end
                `OCM_MODE_DBL_SS, `OCM_MODE_DBL_CONT: begin
                    if (compare_state == ST_WAIT_PRI && pri_hit) begin
                        next_pin = 1'h1; // R4 R5
                        next_state = ST_WAIT_SEC;
                    end else if (compare_state == ST_WAIT_SEC && sec_hit) begin
                        next_pin = 1'h0; // R4 R5
                        // Single shot stops, continuous rearms
                        next_state = (mode == `OCM_MODE_DBL_SS) ? ST_DONE : ST_WAIT_PRI;
                    end
                end
                `OCM_MODE_PWM_EDGE: begin
                    // Primary wins, so a zero duty stays low
                    if (pri_hit) begin
                        next_pin = 1'h0; // R3
                    end else if (zero_hit) begin
                        next_pin = 1'h1; // R3
                    end
                end
                `OCM_MODE_PWM_CTR: begin
                    // Secondary wins when both values are equal
                    if (sec_hit) begin
                        next_pin = 1'h0; // R2
                    end else if (pri_hit) begin
                        next_pin = 1'h1; // R2
                    end
                end
                default: begin
                    next_pin = 1'h0;
                    next_state = ST_OFF;
                end
            endcase
        end
    end

    // Pin and sequence registers
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            compare_output_pin <= `OCM_PIN_RST;
            compare_state <= ST_OFF;
        end else begin
            compare_output_pin <= next_pin;
            compare_state <= next_state;
        end
    end

    // Steady mode qualifier for the checks below
    logic steady; // Enabled, mode unchanged
    assign steady = clk_en && !mode_chg;

    // Checks

    // Mode field reaches the held mode
    property p_mode_field;
        @(posedge ref_clk) disable iff (!rst_n)
        clk_en |=> mode_q == $past(compare_control_one[2:0]);
    endproperty
    a_mode_field: assert property (p_mode_field) else $error("mode field not taken"); // R1

    // Rising step of the single-shot high mode
    sequence s_ss_hi_fire;
        steady && mode == `OCM_MODE_SS_HI && compare_state == ST_WAIT_PRI && pri_hit;
    endsequence

    property p_ss_hi;
        @(posedge ref_clk) disable iff (!rst_n)
        s_ss_hi_fire |=> compare_output_pin && compare_state == ST_DONE;
    endproperty
    a_ss_hi: assert property (p_ss_hi) else $error("single shot high missed"); // R8

    // Once fired high, stays high while mode holds
    property p_ss_hi_hold;
        @(posedge ref_clk) disable iff (!rst_n)
        (mode_q == `OCM_MODE_SS_HI && compare_state == ST_DONE) |-> compare_output_pin;
    endproperty
    a_ss_hi_hold: assert property (p_ss_hi_hold) else $error("single shot high not held"); // R8

    // Start levels on mode entry
    property p_start_level;
        @(posedge ref_clk) disable iff (!rst_n)
        (clk_en && mode_chg) |=> compare_output_pin == ($past(mode) == `OCM_MODE_SS_LO);
    endproperty
    a_start_level: assert property (p_start_level) else $error("wrong start level"); // R7

    // Single-shot low fires low and is still low one cycle later
    property p_ss_lo;
        @(posedge ref_clk) disable iff (!rst_n)
        (steady && mode == `OCM_MODE_SS_LO && compare_state == ST_WAIT_PRI && pri_hit)
            |=> !compare_output_pin ##1 (mode_q != `OCM_MODE_SS_LO || !compare_output_pin);
    endproperty
    a_ss_lo: assert property (p_ss_lo) else $error("single shot low missed"); // R7

    // Toggle mode flips the pin on a primary match
    property p_toggle;
        @(posedge ref_clk) disable iff (!rst_n)
        (steady && mode == `OCM_MODE_TOGGLE && pri_hit) |=> compare_output_pin != $past(compare_output_pin);
    endproperty
    a_toggle: assert property (p_toggle) else $error("toggle missed"); // R6

    // Double compare: secondary match ends the pulse
    sequence s_dbl_end;
        steady && (mode == `OCM_MODE_DBL_SS || mode == `OCM_MODE_DBL_CONT)
            && compare_state == ST_WAIT_SEC && sec_hit;
    endsequence

    property p_dbl_end;
        @(posedge ref_clk) disable iff (!rst_n)
        s_dbl_end |=> !compare_output_pin
            && compare_state == (($past(mode) == `OCM_MODE_DBL_SS) ? ST_DONE : ST_WAIT_PRI);
    endproperty
    a_dbl_end: assert property (p_dbl_end) else $error("double compare end wrong"); // R4

    // Single-shot double compare stays quiet after its pulse
    property p_dbl_ss_quiet;
        @(posedge ref_clk) disable iff (!rst_n)
        (mode_q == `OCM_MODE_DBL_SS && compare_state == ST_DONE) |-> !compare_output_pin;
    endproperty
    a_dbl_ss_quiet: assert property (p_dbl_ss_quiet) else $error("extra pulse"); // R5

    // Edge PWM rises at zero
    property p_pwm_edge;
        @(posedge ref_clk) disable iff (!rst_n)
        (steady && mode == `OCM_MODE_PWM_EDGE && zero_hit && !pri_hit) |=> compare_output_pin;
    endproperty
    a_pwm_edge: assert property (p_pwm_edge) else $error("edge pwm rise missed"); // R3

    // Center PWM rises at primary, falls at secondary
    property p_pwm_ctr;
        @(posedge ref_clk) disable iff (!rst_n)
        (steady && mode == `OCM_MODE_PWM_CTR && (pri_hit || sec_hit)) |=> compare_output_pin == !$past(sec_hit);
    endproperty
    a_pwm_ctr: assert property (p_pwm_ctr) else $error("center pwm level wrong"); // R2

    // Disabled channel holds the pin low
    property p_off;
        @(posedge ref_clk) disable iff (!rst_n)
        (clk_en && mode == `OCM_MODE_OFF) |=> !compare_output_pin && compare_state == ST_OFF;
    endproperty
    a_off: assert property (p_off) else $error("disabled channel active"); // R9

    // Outside PWM the written values are used directly
    property p_direct;
        @(posedge ref_clk) disable iff (!rst_n)
        (clk_en && !pwm) |=> act == $past(written);
    endproperty
    a_direct: assert property (p_direct) else $error("values not taken directly"); // R10

    // In PWM the values in use only change at the period tick or on mode entry
    property p_buffered;
        @(posedge ref_clk) disable iff (!rst_n)
        (pwm && !timer_period_tick && !mode_chg) |=> $stable(act);
    endproperty
    a_buffered: assert property (p_buffered) else $error("pwm values changed mid period"); // R11

    // Double compare: primary match starts the pulse
    sequence s_dbl_rise;
        steady && (mode == `OCM_MODE_DBL_SS || mode == `OCM_MODE_DBL_CONT)
            && compare_state == ST_WAIT_PRI && pri_hit;
    endsequence

    property p_dbl_rise;
        @(posedge ref_clk) disable iff (!rst_n)
        s_dbl_rise |=> compare_output_pin && compare_state == ST_WAIT_SEC;
    endproperty
    a_dbl_rise: assert property (p_dbl_rise) else $error("double compare start wrong"); // R5

    // Enable low freezes pin and sequence
    property p_freeze;
        @(posedge ref_clk) disable iff (!rst_n)
        !clk_en |=> $stable(compare_output_pin) && $stable(compare_state);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while frozen"); // R9

endmodule : ocm_core

//--- hdl/ocm_map.svh
// Constants of the output compare mode logic
// Function
// R1 - Mode is bits two to zero
// R2 - Center PWM: high at primary, low at secondary
// R3 - Edge PWM: high at zero, low at primary
// R4 - Start low, toggle alternate matches forever
// R5 - Start low, one pulse, then quiet
// R6 - Toggle on every primary match
// R7 - Start high, low on primary match
// R8 - Start low, high on primary match
// R9 - Mode zero disables the channel
// R10 - Compare values double-buffered in PWM only
// R11 - Buffered values load at period boundary
`ifndef OCM_MAP_SVH
`define OCM_MAP_SVH

// Widths of the timer and control word
`define OCM_CNT_W 16
`define OCM_CTRL_W 16

// Mode field position in control one
`define OCM_MODE_MSB 2
`define OCM_MODE_LSB 0

// Mode field codes
`define OCM_MODE_OFF 3'h0
`define OCM_MODE_SS_HI 3'h1
`define OCM_MODE_SS_LO 3'h2
`define OCM_MODE_TOGGLE 3'h3
`define OCM_MODE_DBL_SS 3'h4
`define OCM_MODE_DBL_CONT 3'h5
`define OCM_MODE_PWM_EDGE 3'h6
`define OCM_MODE_PWM_CTR 3'h7

// Reset values
`define OCM_MODE_RST 3'h0
`define OCM_PIN_RST 1'h0
`define OCM_CMP_RST 16'h0000
`define OCM_CNT_ZERO 16'h0000

`endif

//--- hdl/ocm_pkg.sv
// Types shared by the output compare mode logic
`include "ocm_map.svh"

package ocm_pkg;

    // Sequence position of the channel
    typedef enum logic [1:0] {
        ST_OFF,
        ST_WAIT_PRI,
        ST_WAIT_SEC,
        ST_DONE
    } ocm_state_t;

    // Timer or compare word
    typedef logic [`OCM_CNT_W-1:0] ocm_cnt_t;

    // Primary and secondary compare values travel together
    typedef struct packed {
        ocm_cnt_t pri;
        ocm_cnt_t sec;
    } ocm_cmp_pair_t;

endpackage : ocm_pkg

//--- hdl/ocm_cmp_buffer.sv
// Active compare value pair, reloaded on command
`timescale 1ns/1ps
`include "ocm_map.svh"

module ocm_cmp_buffer
    import ocm_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Load control and written values
    input wire logic load,
    input ocm_cmp_pair_t written,
    // Values the comparators use
    output ocm_cmp_pair_t active
);

    ocm_cmp_pair_t next_active; // Value for next edge

    // Take the written pair only when told to
    always_comb begin
        next_active = active;
        if (clk_en && load) begin
            next_active = written;
        end
    end

    // Plain register, cleared by reset
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            active <= '{pri: `OCM_CMP_RST, sec: `OCM_CMP_RST};
        end else begin
            active <= next_active;
        end
    end

endmodule : ocm_cmp_buffer

//--- bench/ocm_core_tb_top.sv
// Self-checking bench of the output compare mode logic
`timescale 1ns/1ps
`include "ocm_map.svh"

module ocm_core_tb_top
    import ocm_pkg::*;
;
    // Timer period in counts, short to keep the run brief
    localparam int PER = 20;

    // Clock, reset, enable, timer
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b0;
    logic tick = 1'b0;
    ocm_cnt_t cnt = 16'h0000;
    // Software settings
    logic [15:0] ctrl = 16'h0000;
    ocm_cnt_t pri = 16'h0005;
    ocm_cnt_t sec = 16'h000A;
    // Observed outputs
    logic pin;
    ocm_state_t st;
    // Counters and random state
    int n_fail = 0;
    int tests_run = 0;
    bit [31:0] seed = 32'h2238;
    // Reference model state
    logic [2:0] m_mode = 3'h0;
    logic m_pin = 1'b0;
    ocm_state_t m_st = ST_OFF;
    ocm_cnt_t m_pri = 16'h0000;
    ocm_cnt_t m_sec = 16'h0000;
    logic h_p = 1'b0;
    logic h_s = 1'b0;
    logic h_z = 1'b0;

    // Free-running bench clock
    always #20 ref_clk = ~ref_clk;

    ocm_core i_ocm_core (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .compare_control_one(ctrl),
        .primary_compare_value(pri),
        .secondary_compare_value(sec),
        .compare_timer_count(cnt),
        .timer_period_tick(tick),
        .compare_output_pin(pin),
        .compare_state(st)
    );

    // Repeatable xorshift source
    function automatic bit [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    // One enabled cycle of the expected channel behaviour
    task automatic step();
        logic [2:0] mi;
        logic ep, es, ez, chg;
        mi = ctrl[2:0];
        chg = (mi != m_mode);
        // Edge of equality, so a held count fires once
        ep = (cnt == m_pri) && !h_p;
        es = (cnt == m_sec) && !h_s;
        ez = (cnt == 16'h0000) && !h_z;
        h_p = (cnt == m_pri);
        h_s = (cnt == m_sec);
        h_z = (cnt == 16'h0000);
        // PWM holds values until the period boundary
        if (!(mi[2] && mi[1]) || tick || chg) begin
            m_pri = pri;
            m_sec = sec;
        end
        if (chg) begin
            // Mode entry only applies the start level
            m_mode = mi;
            m_pin = (mi == 3'h2);
            m_st = (mi == 3'h0) ? ST_OFF : ST_WAIT_PRI;
        end else begin
            case (m_mode)
                3'h0: m_pin = 1'b0;
                3'h1, 3'h2: if (ep && m_st == ST_WAIT_PRI) begin
                    m_pin = ~m_pin;
                    m_st = ST_DONE;
                end
                3'h3: if (ep) m_pin = ~m_pin;
                3'h4, 3'h5: if (ep && m_st == ST_WAIT_PRI) begin
                    m_pin = 1'b1;
                    m_st = ST_WAIT_SEC;
                end else if (es && m_st == ST_WAIT_SEC) begin
                    m_pin = 1'b0;
                    m_st = m_mode[0] ? ST_WAIT_PRI : ST_DONE;
                end
                // Primary wins a tie in edge PWM
                3'h6: begin
                    if (ep) begin
                        m_pin = 1'b0;
                    end else if (ez) begin
                        m_pin = 1'b1;
                    end
                end
                // Secondary wins a tie in centre PWM
                default: begin
                    if (es) begin
                        m_pin = 1'b0;
                    end else if (ep) begin
                        m_pin = 1'b1;
                    end
                end
            endcase
        end
    endtask : step

    // Model follows the design's reset and enable
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            m_mode = 3'h0;
            m_pin = 1'b0;
            m_st = ST_OFF;
            m_pri = 16'h0000;
            m_sec = 16'h0000;
            h_p = 1'b0;
            h_s = 1'b0;
            h_z = 1'b0;
        end else if (clk_en) begin
            step();
        end
    end

    // Compare pin, and state when with_st is set, which every mode does
    task automatic cmp(input bit with_st);
        tests_run++;
        if (pin !== m_pin) begin
            n_fail++;
            $display("CHECK FAILED compare_output_pin expected %b seen %b", m_pin, pin);
        end
        if (with_st && st !== m_st) begin
            n_fail++;
            $display("CHECK FAILED compare_state expected %0d seen %0d", m_st, st);
        end
    endtask : cmp

    // Outputs looked at once they have settled
    always @(posedge ref_clk) begin
        #2;
        if (rst_n) begin
            case (m_mode)
                3'h0: cmp(1'b1);
                3'h1: cmp(1'b1);
                3'h2: cmp(1'b1);
                3'h3: cmp(1'b1);
                3'h4: cmp(1'b1);
                3'h5: cmp(1'b1);
                3'h6: cmp(1'b1);
                default: cmp(1'b1);
            endcase
        end
    end

    // Drive one mode for n cycles, values changed at random if asked
    task automatic run(input logic [2:0] md, input int n, input bit rnd);
        bit [31:0] r;
        for (int i = 0; i < n; i++) begin
            @(posedge ref_clk);
            #1;
            r = xs();
            // Unused control bits carry noise
            ctrl = {r[15:3], md};
            // Occasional freeze cycles
            clk_en = (r[18:16] != 3'h0);
            cnt = (cnt == 16'(PER - 1)) ? 16'h0000 : cnt + 16'h0001;
            tick = (cnt == 16'h0000);
            if (rnd && r[23:20] == 4'h0) begin
                pri = 16'(xs() % PER);
                sec = 16'(xs() % PER);
            end
        end
    endtask : run

    // Report the counts and end the run
    task automatic give_verdict();
        $display("Checks run %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : give_verdict

    // Hang guard, well beyond the expected 3752 cycles
    initial begin
        #(40 * 12000);
        n_fail++;
        $display("CHECK FAILED watchdog expected finish seen timeout");
        give_verdict();
    end

    // Main sequence
    initial begin
        repeat (16) @(posedge ref_clk);
        #1;
        rst_n = 1'b1;
        // Every mode code, re-entered through disabled
        for (int p = 0; p < 2; p++) begin
            for (int k = 0; k < 8; k++) begin
                run(3'h0, 8, 1'b1);
                run(k[2:0], 200, 1'b1);
            end
        end
        // Edge PWM with primary at zero: tie at the boundary
        run(3'h0, 4, 1'b0);
        pri = 16'h0000;
        sec = 16'h0007;
        run(3'h6, 80, 1'b0);
        // Centre PWM with equal values: tie at one count
        pri = 16'h0009;
        sec = 16'h0009;
        run(3'h7, 80, 1'b0);
        // Re-selecting a finished single shot must not rearm it
        run(3'h1, 60, 1'b0);
        run(3'h1, 60, 1'b0);
        // Reset in mid-run, mode still selected on release
        run(3'h5, 40, 1'b1);
        @(posedge ref_clk);
        #1;
        rst_n = 1'b0;
        repeat (3) @(posedge ref_clk);
        #1;
        rst_n = 1'b1;
        run(3'h5, 80, 1'b1);
        give_verdict();
    end
endmodule : ocm_core_tb_top
